//--- rtl/acc_consts.vh
`ifndef ACC_CONSTS_VH
`define ACC_CONSTS_VH
`define ACC_CH_ONE 2'h0
`define ACC_CH_TWO 2'h1
`define ACC_CH_TEMP 2'h2
`define ACC_CFG_A_RST 16'h0000
`define ACC_CFG_B_RST 16'h0000
`define ACC_ADDR_CH1_A 4'h2
`define ACC_ADDR_CH1_B 4'h3
`define ACC_ADDR_CH2_A 4'h5
`define ACC_ADDR_CH2_B 4'h6
`define ACC_ADDR_TMP_A 4'h8
`define ACC_ADDR_TMP_B 4'h9
`define ACC_ADDR_STATUS 4'hA
`define ACC_GAIN_MSB 15
`define ACC_GAIN_LSB 11
`define ACC_CLK_MSB 10
`define ACC_CLK_LSB 8
`define ACC_RES_MSB 6
`define ACC_RES_LSB 4
`define ACC_OFS_MSB 3
`define ACC_OFS_LSB 0
`define ACC_BIAS_MSB 6
`define ACC_BIAS_LSB 4
`define ACC_REF_MSB 1
`define ACC_REF_LSB 0
`define ACC_MIN_DIV_LOG2 2
`define ACC_CLKS_RES0 12'h100
`define ACC_CLKS_RES1 12'h140
`define ACC_CLKS_RES2 12'h200
`define ACC_CLKS_RES3 12'h280
`define ACC_CLKS_RES4 12'h320
`define ACC_CLKS_RES5 12'h500
`define ACC_CLKS_RES6 12'h800
`define ACC_RANGE_LOW 2'h0
`define ACC_RANGE_MID 2'h1
`define ACC_RANGE_HIGH 2'h2
`define ACC_RANGE_NONE 2'h3
`endif

//--- rtl/acc_clock_divider.v
`default_nettype none
`include "acc_consts.vh"
module acc_clock_divider #(
	parameter CNT_W = 9
) (
	// Clock and reset.
	input wire clk_i,
	input wire sys_rst_i,
	// Control.
	input wire run_i,
	input wire [2:0] conv_clock_select_i,
	// Converter clock tick.
	output reg tick_o
);
	reg [CNT_W-1:0] count;
	wire [CNT_W-1:0] last;
	wire [3:0] shift;
	// The shift is four bits wide so that codes 6 and 7 do not wrap back to small divisors.
	assign shift = {1'b0, conv_clock_select_i} + 4'h2;
	// Divisor is 2^(code+2), so the terminal count is that minus one.
	assign last = ({{(CNT_W-1){1'b0}}, 1'b1} << shift) - {{(CNT_W-1){1'b0}}, 1'b1};
	always @(posedge clk_i) begin
		if (sys_rst_i || !run_i) begin
			count <= {CNT_W{1'b0}};
			tick_o <= 1'b0;
		end else if (count >= last) begin
			count <= {CNT_W{1'b0}};
			tick_o <= 1'b1;
		end else begin
			count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
			tick_o <= 1'b0;
		end
	end
endmodule
`default_nettype wire

//--- rtl/acc_conversion_config.v
`default_nettype none
`include "acc_consts.vh"
module acc_conversion_config (
	// Clock and reset.
	input wire clk_i,
	input wire sys_rst_i,
	// Register port.
	input wire [3:0] reg_addr_i,
	input wire [15:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	output reg [15:0] reg_rdata_o,
	// Conversion control.
	input wire conv_start_i,
	input wire [1:0] conv_channel_i,
	output reg conv_busy_o,
	output reg conv_done_o,
	output reg conv_error_o,
	output reg conv_tick_o,
	// Analog controls.
	output reg [16:0] gain_sel_onehot_o,
	output reg gain_bypass_o,
	output reg [3:0] coarse_offset_code_o,
	output reg [1:0] offset_range_o,
	output reg [7:0] bias_enable_o,
	output reg [2:0] reference_enable_o
);
	localparam ST_IDLE = 1'b0;
	localparam ST_RUN = 1'b1;
	reg [15:0] chan1_conv_cfg_a, chan1_conv_cfg_b, chan2_conv_cfg_a, chan2_conv_cfg_b, temp_conv_cfg_a, temp_conv_cfg_b;
	reg state;
	reg [1:0] cur_chan;
	reg [15:0] act_a, act_b;
	reg [11:0] tick_count;
	reg [15:0] next_rdata;
	reg last_done, last_error;
	wire div_tick;
	wire is_temp;
	wire [4:0] gain_code;
	wire [1:0] ref_code;
	wire [11:0] sel_target;
	wire [4:0] gi;

	// Gain code to one-hot index; 5'h1F marks an undefined code.
	function [4:0] gain_index;
		input [4:0] code;
		begin
			case (code)
				5'h00: gain_index = 5'h00;
				5'h01: gain_index = 5'h01;
				5'h02: gain_index = 5'h02;
				5'h03: gain_index = 5'h03;
				5'h04: gain_index = 5'h04;
				5'h05: gain_index = 5'h05;
				5'h06: gain_index = 5'h06;
				5'h07: gain_index = 5'h07;
				5'h08: gain_index = 5'h08;
				5'h0A: gain_index = 5'h09;
				5'h0C: gain_index = 5'h0A;
				5'h0E: gain_index = 5'h0B;
				5'h10: gain_index = 5'h0C;
				5'h14: gain_index = 5'h0D;
				5'h18: gain_index = 5'h0E;
				5'h1C: gain_index = 5'h0F;
				5'h1E: gain_index = 5'h10;
				default: gain_index = 5'h1F;
			endcase
		end
	endfunction

	// Resolution code to converter clocks per conversion; zero marks code 7.
	function [11:0] res_clocks;
		input [2:0] code;
		begin
			case (code)
				3'h0: res_clocks = `ACC_CLKS_RES0;
				3'h1: res_clocks = `ACC_CLKS_RES1;
				3'h2: res_clocks = `ACC_CLKS_RES2;
				3'h3: res_clocks = `ACC_CLKS_RES3;
				3'h4: res_clocks = `ACC_CLKS_RES4;
				3'h5: res_clocks = `ACC_CLKS_RES5;
				3'h6: res_clocks = `ACC_CLKS_RES6;
				default: res_clocks = 12'h000;
			endcase
		end
	endfunction

	// Gain code band that sets the coarse-offset step.
	function [1:0] offset_band;
		input [4:0] code;
		begin
			if (code <= 5'h08)
				offset_band = `ACC_RANGE_LOW;
			else if (code >= 5'h0A && code <= 5'h10)
				offset_band = `ACC_RANGE_MID;
			else if (code >= 5'h14 && code <= 5'h1E)
				offset_band = `ACC_RANGE_HIGH;
			else
				offset_band = `ACC_RANGE_NONE;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	acc_clock_divider #(.CNT_W(9)) u_div (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.run_i(state == ST_RUN),
		.conv_clock_select_i(act_a[`ACC_CLK_MSB:`ACC_CLK_LSB]),
		.tick_o(div_tick)
	);

	// Channel codes 2 and 3 both select the temperature channel.
	assign is_temp = cur_chan[1];
	assign gain_code = act_a[`ACC_GAIN_MSB:`ACC_GAIN_LSB];
	assign ref_code = act_b[`ACC_REF_MSB:`ACC_REF_LSB];
	assign gi = gain_index(gain_code);
	assign sel_target = res_clocks(act_a[`ACC_RES_MSB:`ACC_RES_LSB]);

	////////////////////////////////////////////////////////////////////////////////
	// Register writes and reads.
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			chan1_conv_cfg_a <= `ACC_CFG_A_RST;
			chan1_conv_cfg_b <= `ACC_CFG_B_RST;
			chan2_conv_cfg_a <= `ACC_CFG_A_RST;
			chan2_conv_cfg_b <= `ACC_CFG_B_RST;
			temp_conv_cfg_a <= `ACC_CFG_A_RST;
			temp_conv_cfg_b <= `ACC_CFG_B_RST;
		end else if (reg_wr_i) begin
			case (reg_addr_i)
				`ACC_ADDR_CH1_A: chan1_conv_cfg_a <= reg_wdata_i & 16'hFF7F;
				`ACC_ADDR_CH1_B: chan1_conv_cfg_b <= reg_wdata_i & 16'h0073;
				`ACC_ADDR_CH2_A: chan2_conv_cfg_a <= reg_wdata_i & 16'hFF7F;
				`ACC_ADDR_CH2_B: chan2_conv_cfg_b <= reg_wdata_i & 16'h0073;
				`ACC_ADDR_TMP_A: temp_conv_cfg_a <= reg_wdata_i & 16'h077F;
				`ACC_ADDR_TMP_B: temp_conv_cfg_b <= reg_wdata_i & 16'h0070;
				default: begin
				end
			endcase
		end
	end

	always @* begin
		case (reg_addr_i)
			`ACC_ADDR_CH1_A: next_rdata = chan1_conv_cfg_a;
			`ACC_ADDR_CH1_B: next_rdata = chan1_conv_cfg_b;
			`ACC_ADDR_CH2_A: next_rdata = chan2_conv_cfg_a;
			`ACC_ADDR_CH2_B: next_rdata = chan2_conv_cfg_b;
			`ACC_ADDR_TMP_A: next_rdata = temp_conv_cfg_a;
			`ACC_ADDR_TMP_B: next_rdata = temp_conv_cfg_b;
			`ACC_ADDR_STATUS: next_rdata = {11'h000, cur_chan, last_error, last_done, state};
			default: next_rdata = 16'h0000;
		endcase
	end

	always @(posedge clk_i) begin
		if (sys_rst_i)
			reg_rdata_o <= 16'h0000;
		else if (reg_rd_i)
			reg_rdata_o <= next_rdata;
		else
			reg_rdata_o <= 16'h0000;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Conversion sequencer.
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			state <= ST_IDLE;
			cur_chan <= `ACC_CH_ONE;
			act_a <= 16'h0000;
			act_b <= 16'h0000;
			tick_count <= 12'h000;
			conv_busy_o <= 1'b0;
			conv_done_o <= 1'b0;
			conv_error_o <= 1'b0;
			conv_tick_o <= 1'b0;
			last_done <= 1'b0;
			last_error <= 1'b0;
		end else begin
			conv_done_o <= 1'b0;
			conv_error_o <= 1'b0;
			conv_tick_o <= div_tick;
			case (state)
				ST_IDLE: begin
					if (conv_start_i) begin
						cur_chan <= conv_channel_i;
						tick_count <= 12'h000;
						case (conv_channel_i)
							`ACC_CH_ONE: begin
								act_a <= chan1_conv_cfg_a;
								act_b <= chan1_conv_cfg_b;
							end
							`ACC_CH_TWO: begin
								act_a <= chan2_conv_cfg_a;
								act_b <= chan2_conv_cfg_b;
							end
							default: begin
								act_a <= temp_conv_cfg_a;
								act_b <= temp_conv_cfg_b;
							end
						endcase
						state <= ST_RUN;
						conv_busy_o <= 1'b1;
						last_done <= 1'b0;
					end
				end
				ST_RUN: begin
					if (sel_target == 12'h000) begin
						state <= ST_IDLE;
						conv_busy_o <= 1'b0;
						conv_error_o <= 1'b1;
						last_error <= 1'b1;
					end else if (div_tick) begin
						if (tick_count + 12'h001 == sel_target) begin
							state <= ST_IDLE;
							conv_busy_o <= 1'b0;
							conv_done_o <= 1'b1;
							last_done <= 1'b1;
							last_error <= 1'b0;
						end
						tick_count <= tick_count + 12'h001;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Analog control decode from the active channel settings.
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			gain_sel_onehot_o <= 17'h00000;
			gain_bypass_o <= 1'b0;
			coarse_offset_code_o <= 4'h0;
			offset_range_o <= `ACC_RANGE_LOW;
			bias_enable_o <= 8'h00;
			reference_enable_o <= 3'h0;
		end else if (state == ST_RUN) begin
			// The temperature channel has no gain stage, so the amplifier is bypassed.
			gain_bypass_o <= is_temp;
			gain_sel_onehot_o <= (is_temp || gi == 5'h1F) ? 17'h00000 : (17'h00001 << gi);
			coarse_offset_code_o <= act_a[`ACC_OFS_MSB:`ACC_OFS_LSB];
			offset_range_o <= is_temp ? `ACC_RANGE_LOW : offset_band(gain_code);
			// Thermometer code: (code+1) of eight bias cells on.
			bias_enable_o <= ~(8'hFE << act_b[`ACC_BIAS_MSB:`ACC_BIAS_LSB]);
			reference_enable_o <= (is_temp || ref_code == 2'h3) ? 3'h0 : (3'h1 << ref_code);
		end else begin
			gain_sel_onehot_o <= 17'h00000;
			gain_bypass_o <= 1'b0;
			bias_enable_o <= 8'h00;
			reference_enable_o <= 3'h0;
		end
	end
endmodule
`default_nettype wire

//--- tb/acc_cfg_checker.sv
`default_nettype none
module acc_cfg_checker (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Watched ports.
	input wire logic conv_start_i,
	input wire logic conv_busy_o,
	input wire logic conv_done_o,
	input wire logic conv_error_o,
	input wire logic conv_tick_o,
	input wire logic [16:0] gain_sel_onehot_o,
	input wire logic gain_bypass_o,
	input wire logic [1:0] offset_range_o,
	input wire logic [7:0] bias_enable_o,
	input wire logic [2:0] reference_enable_o
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);
	a_start_busy: assert property (conv_start_i && !conv_busy_o |=> conv_busy_o || conv_error_o)
		else $error("start not taken");
	a_done_ends: assert property (conv_done_o |-> !conv_busy_o && $past(conv_busy_o))
		else $error("done without busy end");
	a_done_pulse: assert property (conv_done_o |=> !conv_done_o && (!conv_busy_o || $past(conv_start_i)))
		else $error("done too long");
	a_tick_gap: assert property (conv_tick_o |=> !conv_tick_o [*3])
		else $error("ticks too close");
	a_gain_onehot: assert property ($onehot0(gain_sel_onehot_o))
		else $error("gain not one-hot");
	a_temp_nogain: assert property (gain_bypass_o |-> gain_sel_onehot_o == 17'h00000)
		else $error("temp with gain");
	a_range_low: assert property (|gain_sel_onehot_o[8:0] |-> offset_range_o == 2'h0)
		else $error("low range wrong");
	a_range_high: assert property (|gain_sel_onehot_o[16:13] |-> offset_range_o == 2'h2)
		else $error("high range wrong");
	a_range_mid: assert property (|gain_sel_onehot_o[12:9] |-> offset_range_o == 2'h1)
		else $error("mid range wrong");
	a_bias_thermo: assert property ((bias_enable_o & (bias_enable_o + 8'h01)) == 8'h00)
		else $error("bias not thermometer");
	a_ref_onehot: assert property ($onehot0(reference_enable_o))
		else $error("reference not one-hot");
	a_error_pulse: assert property (conv_error_o |=> !conv_error_o)
		else $error("error too long");
endmodule
bind acc_conversion_config acc_cfg_checker u_acc_cfg_checker (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
	.conv_start_i(conv_start_i), .conv_busy_o(conv_busy_o), .conv_done_o(conv_done_o),
	.conv_error_o(conv_error_o), .conv_tick_o(conv_tick_o), .gain_sel_onehot_o(gain_sel_onehot_o),
	.gain_bypass_o(gain_bypass_o), .offset_range_o(offset_range_o), .bias_enable_o(bias_enable_o),
	.reference_enable_o(reference_enable_o));
`default_nettype wire

//--- tb/acc_cpu_model.sv
`default_nettype none
module acc_cpu_model (
	// Clock.
	input wire logic clk_i,
	// Register port and conversion control.
	output logic [3:0] reg_addr_o,
	output logic [15:0] reg_wdata_o,
	output logic reg_wr_o,
	output logic reg_rd_o,
	input wire logic [15:0] reg_rdata_i,
	output logic conv_start_o,
	output logic [1:0] conv_channel_o
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		{reg_addr_o, reg_wdata_o, reg_wr_o, reg_rd_o, conv_start_o, conv_channel_o} = '0;
	end
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_i);
		reg_addr_o <= a;
		reg_wdata_o <= d;
		reg_wr_o <= 1'b1;
		@(posedge clk_i);
		reg_wr_o <= 1'b0;
		reg_wdata_o <= ~d;
	endtask
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk_i);
		reg_addr_o <= a;
		reg_rd_o <= 1'b1;
		@(posedge clk_i);
		reg_rd_o <= 1'b0;
		reg_addr_o <= ~a;
		#1;
		d = reg_rdata_i;
	endtask
	task automatic cfg(input logic [1:0] ch, input logic [4:0] g, input logic [2:0] ck, input logic [2:0] rs,
		input logic [3:0] of, input logic [2:0] bs, input logic [1:0] rf);
		logic [2:0] lim;
		lim = 3'h3 - {1'b0, bs[2:1]};
		if (ck < lim) ck = lim;
		wr(4'h2 + 4'h3 * {2'h0, ch}, {g, ck, 1'b0, rs, of});
		wr(4'h3 + 4'h3 * {2'h0, ch}, {9'h000, bs, 2'h0, rf});
	endtask
	task automatic start(input logic [1:0] c);
		@(posedge clk_i);
		conv_start_o <= 1'b1;
		conv_channel_o <= c;
		@(posedge clk_i);
		conv_start_o <= 1'b0;
		conv_channel_o <= ~c;
		#1;
	endtask
endmodule
`default_nettype wire

//--- tb/acc_conversion_config_tb.sv
`default_nettype none
module acc_conversion_config_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_i, sys_rst_i, wr, rd, start, busy, done, error, tick, bypass;
	logic [3:0] addr, ofs;
	logic [15:0] wdata, rdata;
	logic [1:0] chan, range;
	logic [16:0] gain;
	logic [7:0] bias;
	logic [2:0] refe;
	int err_count = 0, compares = 0, cyc = 0;
	logic [4:0] gc [18] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08,
		5'h0A, 5'h0C, 5'h0E, 5'h10, 5'h14, 5'h18, 5'h1C, 5'h1E, 5'h09};
	logic [3:0] ra [6] = '{4'h2, 4'h3, 4'h5, 4'h6, 4'h8, 4'h9};
	logic [15:0] rm [6] = '{16'hFF7F, 16'h0073, 16'hFF7F, 16'h0073, 16'h077F, 16'h0070};
	int nres [7] = '{256, 320, 512, 640, 800, 1280, 2048};
	acc_conversion_config u_acc_conversion_config (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .conv_start_i(start),
		.conv_channel_i(chan), .conv_busy_o(busy), .conv_done_o(done), .conv_error_o(error),
		.conv_tick_o(tick), .gain_sel_onehot_o(gain), .gain_bypass_o(bypass), .coarse_offset_code_o(ofs),
		.offset_range_o(range), .bias_enable_o(bias), .reference_enable_o(refe));
	acc_cpu_model u_acc_cpu_model (.clk_i(clk_i), .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_wr_o(wr),
		.reg_rd_o(rd), .reg_rdata_i(rdata), .conv_start_o(start), .conv_channel_o(chan));
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic results();
		$display("compares=%0d mismatches=%0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic conv(input logic [1:0] c);
		u_acc_cpu_model.start(c);
		@(posedge clk_i);
		#1;
	endtask
	// Samples each settled cycle until done or error, counting ticks and the gap between the first two.
	task automatic run(output int tk, output int gap, output logic er);
		int t1;
		{tk, gap, t1, er} = '0;
		for (int n = 0; n < 20000; n++) begin
			if (tick === 1'b1) begin
				tk++;
				if (tk == 1) t1 = n;
				if (tk == 2) gap = n - t1;
			end
			er = (error === 1'b1);
			if (done === 1'b1 || er) break;
			@(posedge clk_i);
			#1;
		end
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_regs();
		logic [15:0] d;
		for (int i = 0; i < 6; i++) begin
			u_acc_cpu_model.rd(ra[i], d);
			chk(d, 0);
			u_acc_cpu_model.wr(ra[i], 16'hFFFF);
			u_acc_cpu_model.rd(ra[i], d);
			chk(d, rm[i]);
		end
		u_acc_cpu_model.wr(4'hA, 16'hFFFF);
		u_acc_cpu_model.rd(4'hA, d);
		chk(d, 0);
		u_acc_cpu_model.rd(4'hF, d);
		chk(d, 0);
		$display("test regs done");
	endtask
	task automatic t_gain();
		int tk, gap, eg;
		logic er;
		for (int i = 0; i < 18; i++) begin
			eg = i < 17 ? 1 << i : 0;
			u_acc_cpu_model.cfg(2'(i % 2), gc[i], 3'h0, 3'h0, 4'(i), 3'(6 + i % 2), 2'(i % 4));
			conv(2'(i % 2));
			chk(gain, eg);
			chk(range, i < 9 ? 0 : i < 13 ? 1 : i < 17 ? 2 : 3);
			chk(ofs, i % 16);
			chk(refe, i % 4 == 3 ? 0 : 1 << (i % 4));
			chk(bias, (1 << (7 + i % 2)) - 1);
			u_acc_cpu_model.wr(4'(2 + 3 * (i % 2)), 16'h4800);
			@(posedge clk_i);
			#1;
			chk(gain, eg);
			run(tk, gap, er);
		end
		$display("test gain done");
	endtask
	task automatic t_temp();
		int tk, gap;
		logic er;
		logic [15:0] d;
		u_acc_cpu_model.cfg(2'h2, 5'h1E, 3'h0, 3'h0, 4'h9, 3'h7, 2'h1);
		conv(2'h3);
		chk({bypass, gain, refe, range, ofs}, {1'b1, 17'h0, 3'h0, 2'h0, 4'h9});
		run(tk, gap, er);
		u_acc_cpu_model.rd(4'hA, d);
		chk(d & 16'h0007, 16'h0002);
		$display("test temp done");
	endtask
	task automatic t_res();
		int tk, gap;
		logic er;
		logic [15:0] d;
		for (int r = 0; r < 8; r++) begin
			u_acc_cpu_model.cfg(2'h0, 5'h00, 3'h0, 3'(r), 4'h0, 3'h7, 2'h0);
			conv(2'h0);
			run(tk, gap, er);
			if (r < 7) chk(tk, nres[r]);
			chk({busy, done}, {1'b0, r < 7});
			chk(er, r == 7);
		end
		u_acc_cpu_model.rd(4'hA, d);
		chk(d & 16'h0004, 16'h0004);
		$display("test res done");
	endtask
	task automatic t_bias();
		int tk, gap;
		logic er;
		for (int b = 0; b < 8; b++) begin
			u_acc_cpu_model.cfg(2'h1, 5'h08, 3'(3 - b / 2), 3'h0, 4'h0, 3'(b), 2'h2);
			conv(2'h1);
			chk(bias, (1 << (b + 1)) - 1);
			chk(busy, 1);
			run(tk, gap, er);
			chk(busy, 0);
			chk(gap, 4 << (3 - b / 2));
			chk(tk, 256);
		end
		$display("test bias done");
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 100000) begin
			err_count++;
			results();
		end
	end
	initial begin
		sys_rst_i = 1'b1;
		repeat (4) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		t_regs();
		t_gain();
		t_temp();
		t_res();
		t_bias();
		results();
	end
endmodule
`default_nettype wire
